// ### hdl/seq_pkg.sv
package seq_pkg;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int US_CYC = 1 * CLK_MHZ;
	localparam int SETTLE_US = 1600;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int MARKER_US = 200;
	localparam int MARKER_CYC = MARKER_US * CLK_MHZ;
	localparam int US_PER_MS = 1000;
	// ---------------------------------------------
	// storage limits
	// ---------------------------------------------
	localparam int NUM_LISTS = 10;
	localparam int LIST_PAIRS_MAX = 2000;
	localparam int SEQ_ENTRIES_MAX = 256;
	localparam logic [5:0] MEM_LOC_MIN = 6'h01;
	localparam logic [5:0] MEM_LOC_MAX = 6'h32;
	localparam logic [15:0] SEQ_DWELL_MIN_MS = 16'h0032;
	localparam logic [15:0] SEQ_DWELL_MAX_MS = 16'hea60;
	localparam logic [25:0] DWELL_RST_US = 26'h0002710;
	localparam logic [15:0] LEVEL_SPAN_MAX = 16'h00c8;
	// ---------------------------------------------
	// register map (word index on the plain port)
	// ---------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h1;
	localparam logic [3:0] REG_DWELL = 4'h2;
	localparam logic [3:0] REG_INDEX = 4'h3;
	localparam logic [3:0] REG_LENGTH = 4'h4;
	localparam logic [3:0] REG_SEQ_PTR = 4'h5;
	localparam logic [3:0] REG_SEQ_DATA = 4'h6;
	localparam logic [3:0] REG_LEVEL_SPAN = 4'h7;
	localparam int CMD_START = 0;
	localparam int CMD_RESET = 1;
	localparam int CMD_PRECOMPUTE_LIST_COMMAND = 2;
	localparam int CMD_SELECT = 3;
	localparam int CMD_DELETE = 4;
	localparam int CMD_SLOT_LSB = 8;
	localparam int FREE_LSB = 16;
	localparam logic [5:0] CTRL_RST = 6'h00;
	// ---------------------------------------------
	// types
	// ---------------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF, MODE_AUTO, MODE_SINGLE, MODE_STEP,
		EXTERNAL_SINGLE_RUN, EXTERNAL_STEP_RUN
	} run_mode_t;
	typedef struct packed {
		logic stored_setting_sequence_mode;
		logic blank_pol;
		logic trigger_edge_polarity;
		run_mode_t mode;
	} ctrl_t;
	typedef struct packed {
		logic [5:0] loc;
		logic [15:0] dwell_ms;
	} seq_entry_t;
	typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_DWELL} run_state_t;
endpackage

// ### hdl/trig_edge_detect.sv
`timescale 1ns/1ns
module trig_edge_detect (
	input wire logic ref_clk_in, // system clock
	input wire logic sys_rst_in, // sync reset, high
	input wire logic trig_in, // asynchronous pin
	input wire logic rising_in, // 1: rising edge active
	output logic edge_out // one-cycle pulse
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic [1:0] fill_q;
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			fill_q <= 2'h0;
		end else begin
			s1_q <= trig_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (fill_q != 2'h3) begin
				fill_q <= fill_q + 2'h1;
			end
		end
	end
	// no edge until the pipe holds real pin samples, whatever the idle level
	assign edge_out = (fill_q == 2'h3) && (rising_in ? (s2_q & ~s3_q) : (~s2_q & s3_q));
endmodule

// ### hdl/list_and_memory_sequencer.sv
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module list_and_memory_sequencer #(
	parameter int SETTLE_CYC = seq_pkg::SETTLE_CYC,
	parameter int MARKER_CYC = seq_pkg::MARKER_CYC
) (
	input wire logic ref_clk_in, // 100 MHz clock
	input wire logic sys_rst_in, // sync reset, high
	input wire logic [3:0] reg_addr_in, // register word index
	input wire logic [31:0] reg_wdata_in, // write data
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	output logic [31:0] reg_rdata_out, // read data, cycle after strobe
	input wire logic trigger_in, // external trigger pin
	output logic blank_out, // blanking level
	output logic marker_out, // first-step marker
	output logic step_load_out, // pulse: new setting applied
	output logic [10:0] index_out, // applied entry, zero based
	output logic [5:0] recall_loc_out, // stored-setting location
	output logic precompute_list_command_out // pulse: recompute settings
);
	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	seq_pkg::ctrl_t ctrl_q;
	logic [25:0] dwell_us_q;
	logic [3:0] sel_q;
	logic [9:0][10:0] list_len_q;
	logic [9:0][10:0] seq_len_q;
	seq_pkg::seq_entry_t seq_mem_q [seq_pkg::SEQ_ENTRIES_MAX];
	logic [8:0] seq_ptr_q;
	logic [15:0] level_span_q;
	logic learned_q;
	logic [31:0] rdata_q;
	logic wr_ctrl, wr_cmd, wr_index, wr_len, wr_data;
	logic [3:0] slot;
	logic [11:0] free_list, free_seq;
	logic [10:0] cur_len;
	logic [10:0] cur_free;
	logic [7:0] seq_base;
	logic [7:0] wr_addr;
	logic [7:0] run_addr;
	seq_pkg::seq_entry_t wr_entry;

	function automatic logic [11:0] sum_below(input logic [9:0][10:0] a, input logic [3:0] n);
		logic [11:0] s;
		s = 12'h000;
		for (int i = 0; i < seq_pkg::NUM_LISTS; i++) begin
			if (4'(i) < n) begin
				s = s + {1'b0, a[i]};
			end
		end
		return s;
	endfunction

	assign wr_ctrl = reg_wr_in && reg_addr_in == seq_pkg::REG_CTRL;
	assign wr_cmd = reg_wr_in && reg_addr_in == seq_pkg::REG_CMD;
	assign wr_index = reg_wr_in && reg_addr_in == seq_pkg::REG_INDEX;
	assign wr_len = reg_wr_in && reg_addr_in == seq_pkg::REG_LENGTH;
	assign wr_data = reg_wr_in && reg_addr_in == seq_pkg::REG_SEQ_DATA;
	assign slot = reg_wdata_in[seq_pkg::CMD_SLOT_LSB +: 4];
	assign wr_entry = reg_wdata_in[21:0];
	assign free_list = 12'(seq_pkg::LIST_PAIRS_MAX) - sum_below(list_len_q, 4'ha);
	assign free_seq = 12'(seq_pkg::SEQ_ENTRIES_MAX) - sum_below(seq_len_q, 4'ha);
	assign seq_base = 8'(sum_below(seq_len_q, sel_q));
	assign cur_len = ctrl_q.stored_setting_sequence_mode ? seq_len_q[sel_q] : list_len_q[sel_q];
	assign cur_free = ctrl_q.stored_setting_sequence_mode ? free_seq[10:0] : free_list[10:0];
	assign wr_addr = seq_base + seq_ptr_q[7:0] - 8'h01;

	// ---------------------------------------------
	// configuration registers
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ctrl_q <= seq_pkg::ctrl_t'(seq_pkg::CTRL_RST);
			dwell_us_q <= seq_pkg::DWELL_RST_US;
			seq_ptr_q <= 9'h001;
			level_span_q <= 16'h0000;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= seq_pkg::ctrl_t'(reg_wdata_in[5:0]);
			end
			// common dwell in microseconds, never zero
			if (reg_wr_in && reg_addr_in == seq_pkg::REG_DWELL) begin
				dwell_us_q <= (reg_wdata_in[25:0] == 26'h0) ? 26'h1 : reg_wdata_in[25:0];
			end
			if (reg_wr_in && reg_addr_in == seq_pkg::REG_SEQ_PTR) begin
				seq_ptr_q <= reg_wdata_in[8:0];
			end
			if (reg_wr_in && reg_addr_in == seq_pkg::REG_LEVEL_SPAN) begin
				level_span_q <= reg_wdata_in[15:0];
			end
		end
	end

	// ---------------------------------------------
	// list directory: select, delete, length
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sel_q <= 4'h0;
			list_len_q <= '0;
			seq_len_q <= '0;
		end else if (wr_cmd && slot < 4'(seq_pkg::NUM_LISTS)) begin
			// select chooses or creates, delete frees the slot
			if (reg_wdata_in[seq_pkg::CMD_SELECT]) begin
				sel_q <= slot;
			end else if (reg_wdata_in[seq_pkg::CMD_DELETE]) begin
				if (ctrl_q.stored_setting_sequence_mode) begin
					seq_len_q[slot] <= 11'h000;
				end else begin
					list_len_q[slot] <= 11'h000;
				end
			end
		end else if (wr_len && reg_wdata_in[10:0] <= cur_len + cur_free) begin
			// pair pool shared by all lists
			if (!ctrl_q.stored_setting_sequence_mode) begin
				list_len_q[sel_q] <= reg_wdata_in[10:0];
			end else begin
				// entry pool shared by all sequences
				seq_len_q[sel_q] <= reg_wdata_in[10:0];
			end
		end
	end

	// ---------------------------------------------
	// sequence entry storage
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (wr_data && seq_ptr_q != 9'h0 && seq_ptr_q[8:0] <= 9'(seq_seq_len())) begin
			if (wr_entry.loc >= seq_pkg::MEM_LOC_MIN && wr_entry.loc <= seq_pkg::MEM_LOC_MAX) begin
				seq_mem_q[wr_addr].loc <= wr_entry.loc;
				// dwell clamped to its legal span
				if (wr_entry.dwell_ms < seq_pkg::SEQ_DWELL_MIN_MS) begin
					seq_mem_q[wr_addr].dwell_ms <= seq_pkg::SEQ_DWELL_MIN_MS;
				end else if (wr_entry.dwell_ms > seq_pkg::SEQ_DWELL_MAX_MS) begin
					seq_mem_q[wr_addr].dwell_ms <= seq_pkg::SEQ_DWELL_MAX_MS;
				end else begin
					seq_mem_q[wr_addr].dwell_ms <= wr_entry.dwell_ms;
				end
			end
		end
	end

	function automatic logic [10:0] seq_seq_len();
		return seq_len_q[sel_q];
	endfunction

	// ---------------------------------------------
	// precompute handshake
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			learned_q <= 1'b0;
			precompute_list_command_out <= 1'b0;
		end else begin
			precompute_list_command_out <= wr_cmd && reg_wdata_in[seq_pkg::CMD_PRECOMPUTE_LIST_COMMAND];
			// set by precompute wins over a same-cycle edit
			if (wr_cmd && reg_wdata_in[seq_pkg::CMD_PRECOMPUTE_LIST_COMMAND]) begin
				learned_q <= 1'b1;
			end else if (wr_len || wr_data || (wr_cmd && reg_wdata_in[seq_pkg::CMD_DELETE])) begin
				learned_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------
	// run engine
	// ---------------------------------------------
	seq_pkg::run_state_t st_q;
	logic [10:0] idx_q;
	logic [6:0] us_div_q;
	logic [25:0] dwell_cnt_q, dwell_tgt_q;
	logic [31:0] settle_cnt_q, marker_cnt_q;
	logic trig_edge;
	logic settle_end_q;
	logic is_last, dwell_done, do_load, go_idle, start_ok, step_ok, idx_ok;
	logic [10:0] load_idx;
	seq_pkg::run_mode_t mode;

	assign mode = ctrl_q.mode;
	assign is_last = idx_q + 11'h1 >= cur_len;
	assign dwell_done = st_q == seq_pkg::ST_DWELL && dwell_cnt_q >= dwell_tgt_q;
	assign run_addr = seq_base + load_idx[7:0];
	assign start_ok = (wr_cmd && reg_wdata_in[seq_pkg::CMD_START] && mode == seq_pkg::MODE_SINGLE)
		|| (trig_edge && mode == seq_pkg::EXTERNAL_SINGLE_RUN && st_q == seq_pkg::ST_IDLE);
	assign step_ok = trig_edge && mode == seq_pkg::EXTERNAL_STEP_RUN;
	assign idx_ok = wr_index && (mode == seq_pkg::MODE_STEP || mode == seq_pkg::EXTERNAL_STEP_RUN)
		&& reg_wdata_in[10:0] != 11'h0 && reg_wdata_in[10:0] <= cur_len;

	trig_edge_detect u_trig (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.trig_in(trigger_in),
		.rising_in(ctrl_q.trigger_edge_polarity),
		.edge_out(trig_edge)
	);

	always_comb begin
		do_load = 1'b0;
		go_idle = 1'b0;
		load_idx = idx_q;
		if (wr_cmd && slot < 4'(seq_pkg::NUM_LISTS) && (reg_wdata_in[seq_pkg::CMD_RESET]
			|| reg_wdata_in[seq_pkg::CMD_SELECT] || reg_wdata_in[seq_pkg::CMD_DELETE])) begin
			go_idle = 1'b1;
			load_idx = 11'h0;
		end else if (cur_len == 11'h0 || mode == seq_pkg::MODE_OFF) begin
			go_idle = 1'b1;
		end else if (idx_ok) begin
			do_load = 1'b1;
			load_idx = reg_wdata_in[10:0] - 11'h1;
		end else if (start_ok) begin
			do_load = 1'b1;
			load_idx = 11'h0;
		end else if (step_ok) begin
			do_load = 1'b1;
			load_idx = is_last ? 11'h0 : idx_q + 11'h1;
		end else if (mode == seq_pkg::MODE_AUTO && st_q == seq_pkg::ST_IDLE) begin
			do_load = 1'b1;
		end else if (dwell_done) begin
			// on dwell expiry: step modes go idle, others increment the index (auto wraps, single stops at last)
			if (mode == seq_pkg::MODE_STEP || mode == seq_pkg::EXTERNAL_STEP_RUN) begin
				go_idle = 1'b1;
			end else if (!is_last) begin
				do_load = 1'b1;
				load_idx = idx_q + 11'h1;
			end else if (mode == seq_pkg::MODE_AUTO) begin
				do_load = 1'b1;
				load_idx = 11'h0;
			end else begin
				go_idle = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			st_q <= seq_pkg::ST_IDLE;
			idx_q <= 11'h0;
			settle_cnt_q <= 32'h0;
		end else begin
			if (do_load || go_idle) begin
				idx_q <= load_idx;
			end
			if (do_load) begin
				st_q <= seq_pkg::ST_SETTLE;
				settle_cnt_q <= 32'h0;
			end else if (go_idle) begin
				st_q <= seq_pkg::ST_IDLE;
			end else if (st_q == seq_pkg::ST_SETTLE) begin
				settle_cnt_q <= settle_cnt_q + 32'h1;
				if (settle_cnt_q == 32'(SETTLE_CYC - 1)) begin
					st_q <= seq_pkg::ST_DWELL;
				end
			end
		end
	end

	// dwell timer in microseconds, started with each load
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			us_div_q <= 7'h0;
			dwell_cnt_q <= 26'h0;
			dwell_tgt_q <= seq_pkg::DWELL_RST_US;
		end else if (do_load) begin
			us_div_q <= 7'h0;
			dwell_cnt_q <= 26'h0;
			// per-entry dwell; common dwell for frequency lists
			dwell_tgt_q <= ctrl_q.stored_setting_sequence_mode
				? 26'(seq_mem_q[run_addr].dwell_ms * 26'(seq_pkg::US_PER_MS)) : dwell_us_q;
		end else begin
			if (us_div_q == 7'(seq_pkg::US_CYC - 1)) begin
				us_div_q <= 7'h0;
				if (dwell_cnt_q != 26'h3ffffff) begin
					dwell_cnt_q <= dwell_cnt_q + 26'h1;
				end
			end else begin
				us_div_q <= us_div_q + 7'h1;
			end
		end
	end

	// ---------------------------------------------
	// pin outputs
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			// idle level of the default active-low blanking
			blank_out <= 1'b1;
			settle_end_q <= 1'b0;
			marker_out <= 1'b0;
			marker_cnt_q <= 32'h0;
			step_load_out <= 1'b0;
			index_out <= 11'h0;
			recall_loc_out <= seq_pkg::MEM_LOC_MIN;
		end else begin
			blank_out <= (st_q == seq_pkg::ST_SETTLE) ~^ ctrl_q.blank_pol;
			step_load_out <= do_load;
			if (do_load) begin
				index_out <= load_idx;
				if (ctrl_q.stored_setting_sequence_mode
					&& seq_mem_q[run_addr].loc >= seq_pkg::MEM_LOC_MIN) begin
					recall_loc_out <= seq_mem_q[run_addr].loc;
				end
			end
			settle_end_q <= st_q == seq_pkg::ST_SETTLE && !do_load && !go_idle
				&& settle_cnt_q == 32'(SETTLE_CYC - 1);
			// marker on first step, as blanking ends; fixed latency
			if (settle_end_q && !do_load && !go_idle && idx_q == 11'h0) begin
				marker_out <= 1'b1;
				marker_cnt_q <= 32'(MARKER_CYC);
			end else if (marker_cnt_q > 32'h1) begin
				marker_cnt_q <= marker_cnt_q - 32'h1;
			end else begin
				marker_out <= 1'b0;
				marker_cnt_q <= 32'h0;
			end
		end
	end

	// ---------------------------------------------
	// register read
	// ---------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rdata_q <= 32'h0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				seq_pkg::REG_CTRL: rdata_q <= {26'h0, ctrl_q};
				seq_pkg::REG_CMD: rdata_q <= {24'h0, sel_q, 1'b0,
					level_span_q > seq_pkg::LEVEL_SPAN_MAX, learned_q, st_q != seq_pkg::ST_IDLE};
				seq_pkg::REG_DWELL: rdata_q <= {6'h0, dwell_us_q};
				seq_pkg::REG_INDEX: rdata_q <= {21'h0, idx_q + 11'h1};
				seq_pkg::REG_LENGTH: rdata_q <= {5'h0, cur_free, 5'h0, cur_len};
				seq_pkg::REG_SEQ_PTR: rdata_q <= {23'h0, seq_ptr_q};
				seq_pkg::REG_SEQ_DATA: rdata_q <= {10'h0, seq_mem_q[wr_addr]};
				seq_pkg::REG_LEVEL_SPAN: rdata_q <= {16'h0, level_span_q};
				default: rdata_q <= 32'h0;
			endcase
		end else begin
			rdata_q <= 32'h0;
		end
	end
	assign reg_rdata_out = rdata_q;

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);

	AST_EXT_TRIG_ONLY: assert property (
		(mode == seq_pkg::EXTERNAL_SINGLE_RUN && st_q == seq_pkg::ST_IDLE && do_load) |-> trig_edge
	) else $error("external single run started without trigger edge");
	AST_BLANK_AFTER_LOAD: assert property (
		do_load |=> ##1 (blank_out == $past(ctrl_q.blank_pol))
	) else $error("blank not active after setting change");
	AST_MARKER_FIRST: assert property (
		$rose(marker_out) |-> (idx_q == 11'h0 && $past(st_q, 2) == seq_pkg::ST_SETTLE
		&& blank_out != $past(ctrl_q.blank_pol))
	) else $error("marker outside first step after blanking");
	AST_MARKER_END: assert property (
		$fell(marker_out) |-> ($past(marker_cnt_q) == 32'h1)
	) else $error("marker length wrong");
	AST_START_SINGLE: assert property (
		(wr_cmd && reg_wdata_in[seq_pkg::CMD_START] && mode != seq_pkg::MODE_SINGLE
		&& st_q == seq_pkg::ST_IDLE && mode != seq_pkg::MODE_AUTO && !trig_edge && !idx_ok)
		|=> st_q == seq_pkg::ST_IDLE
	) else $error("start accepted outside single mode");
	AST_RESET_LIST: assert property (
		(wr_cmd && reg_wdata_in[seq_pkg::CMD_RESET] && slot < 4'ha)
		|=> (idx_q == 11'h0 && st_q == seq_pkg::ST_IDLE)
	) else $error("reset did not return to first entry");
	AST_INDEX_WRITE: assert property (
		idx_ok |=> idx_q == $past(reg_wdata_in[10:0]) - 11'h1
	) else $error("index write not applied");
	AST_EXTERNAL_STEP_RUN_ONE: assert property (
		(step_ok && !idx_ok && !go_idle && !is_last) |=> idx_q == $past(idx_q) + 11'h1
	) else $error("external step did not advance one entry");
	AST_POOLS: assert property (
		free_list <= 12'(seq_pkg::LIST_PAIRS_MAX) && free_seq <= 12'(seq_pkg::SEQ_ENTRIES_MAX)
	) else $error("list storage pool overrun");
	AST_RECALL_RANGE: assert property (
		recall_loc_out >= seq_pkg::MEM_LOC_MIN && recall_loc_out <= seq_pkg::MEM_LOC_MAX
	) else $error("recall location out of range");

	COV_AUTO_WRAP: cover property (dwell_done && is_last && mode == seq_pkg::MODE_AUTO);
	COV_EXTERNAL_STEP_RUN: cover property (step_ok ##1 st_q == seq_pkg::ST_SETTLE);
	COV_MARKER: cover property ($rose(marker_out));
	COV_SEQ_RUN: cover property (do_load && ctrl_q.stored_setting_sequence_mode);
endmodule

// ### verif/trig_source_model.sv
`timescale 1ns/1ns
module trig_source_model (
	input wire logic ref_clk_in, // system clock
	input wire logic marker_in, // marker from generator
	output logic trigger_out // trigger to generator
);
	// ---------------------------------------------
	// timing capture
	// ---------------------------------------------
	time t_edge;
	time t_rise;
	int lat;
	int width;
	initial begin
		trigger_out = 1'b0;
		t_edge = 0;
		t_rise = 0;
		lat = 0;
		width = 0;
	end
	always @(posedge marker_in) begin
		t_rise = $time;
		lat = int'((t_rise - t_edge) / 10);
	end
	always @(negedge marker_in) begin
		width = int'(($time - t_rise) / 10);
	end
	// ---------------------------------------------
	// stimulus
	// ---------------------------------------------
	// one active edge per pulse
	task automatic fire(input logic rise);
		@(posedge ref_clk_in);
		trigger_out <= ~rise;
		repeat (5) @(posedge ref_clk_in);
		trigger_out <= rise;
		t_edge = $time;
		repeat (10) @(posedge ref_clk_in);
		trigger_out <= ~rise;
	endtask
endmodule

// ### verif/list_and_memory_sequencer_tb_top.sv
`timescale 1ns/1ns
module list_and_memory_sequencer_tb_top;
	localparam int SETTLE_T = 20;
	localparam int MARK_T = 5;
	logic ref_clk_in, sys_rst_in, reg_wr_in, reg_rd_in, trigger_in;
	logic [3:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, rv;
	logic blank_out, marker_out, step_load_out, precompute_list_command_out;
	logic [10:0] index_out;
	logic [5:0] recall_loc_out;
	int n_mismatch, checked, n_load, n0;
	list_and_memory_sequencer #(.SETTLE_CYC(SETTLE_T), .MARKER_CYC(MARK_T)) dut (
		.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .trigger_in(trigger_in), .blank_out(blank_out),
		.marker_out(marker_out), .step_load_out(step_load_out), .index_out(index_out),
		.recall_loc_out(recall_loc_out),
		.precompute_list_command_out(precompute_list_command_out));
	trig_source_model peer (.ref_clk_in(ref_clk_in), .marker_in(marker_out),
		.trigger_out(trigger_in));
	// ---------------------------------------------
	// bus and check helpers
	// ---------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge ref_clk_in);
		rv = reg_rdata_out;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 200; i++) begin
			rd(seq_pkg::REG_CMD);
			if (rv[0] === 1'b0) break;
		end
		chk("run ended", 32'(rv[0]), 32'h0);
	endtask
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk_in) if (step_load_out === 1'b1) n_load <= n_load + 1;
	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_reset();
		chk("blank idle", 32'(blank_out), 32'h1);
		chk("marker idle", 32'(marker_out), 32'h0);
		chk("index", 32'(index_out), 32'h0);
		rd(seq_pkg::REG_DWELL);
		chk("dwell", rv, 32'(seq_pkg::DWELL_RST_US));
		rd(seq_pkg::REG_LENGTH);
		chk("free", rv, 32'(seq_pkg::LIST_PAIRS_MAX) << 16);
		rd(4'h8);
		chk("unmapped", rv, 32'h0);
	endtask
	task automatic t_precompute_list_command();
		int seen;
		wr(seq_pkg::REG_LENGTH, 32'h3);
		rd(seq_pkg::REG_LENGTH);
		chk("length", rv, (32'(seq_pkg::LIST_PAIRS_MAX - 3) << 16) | 32'h3);
		seen = 0;
		wr(seq_pkg::REG_CMD, 32'h4);
		repeat (3) @(negedge ref_clk_in) if (precompute_list_command_out === 1'b1) seen++;
		chk("precompute_list_command pulse", 32'(seen), 32'h1);
		rd(seq_pkg::REG_CMD);
		chk("learned flag", rv, 32'h2);
	endtask
	task automatic t_single();
		wr(seq_pkg::REG_DWELL, 32'h1);
		wr(seq_pkg::REG_CTRL, 32'h0);
		n0 = n_load;
		wr(seq_pkg::REG_CMD, 32'h1);
		repeat (60) @(posedge ref_clk_in);
		chk("start refused", 32'(n_load - n0), 32'h0);
		wr(seq_pkg::REG_CTRL, 32'h12);
		n0 = n_load;
		wr(seq_pkg::REG_CMD, 32'h1);
		repeat (8) @(negedge ref_clk_in);
		chk("blank settling", 32'(blank_out), 32'h1);
		wait_idle();
		chk("single loads", 32'(n_load - n0), 32'h3);
		chk("last index", 32'(index_out), 32'h2);
		chk("blank done", 32'(blank_out), 32'h0);
		chk("marker width", 32'(peer.width), 32'(MARK_T));
	endtask
	task automatic t_step();
		wr(seq_pkg::REG_CMD, 32'h2);
		rd(seq_pkg::REG_INDEX);
		chk("reset index", rv, 32'h1);
		wr(seq_pkg::REG_CTRL, 32'h3);
		wr(seq_pkg::REG_INDEX, 32'h3);
		wr(seq_pkg::REG_INDEX, 32'h4);
		rd(seq_pkg::REG_INDEX);
		chk("step index", rv, 32'h3);
		chk("index out", 32'(index_out), 32'h2);
	endtask
	task automatic t_external_step_run();
		wr(seq_pkg::REG_CTRL, 32'h1d);
		wr(seq_pkg::REG_INDEX, 32'h1);
		repeat (150) @(posedge ref_clk_in);
		for (int k = 1; k < 3; k++) begin
			n0 = n_load;
			peer.fire(1'b1);
			repeat (150) @(posedge ref_clk_in);
			chk("one step", 32'(n_load - n0), 32'h1);
			chk("ext index", 32'(index_out), 32'(k));
		end
	endtask
	task automatic t_external_single_run();
		wr(seq_pkg::REG_CMD, 32'h2);
		wr(seq_pkg::REG_CTRL, 32'h14);
		repeat (10) @(posedge ref_clk_in);
		n0 = n_load;
		peer.fire(1'b0);
		repeat (450) @(posedge ref_clk_in);
		chk("ext loads", 32'(n_load - n0), 32'h3);
		chk("latency", 32'(peer.lat >= SETTLE_T && peer.lat <= SETTLE_T + 10), 32'h1);
		chk("ext marker", 32'(peer.width), 32'(MARK_T));
	endtask
	task automatic t_auto();
		wr(seq_pkg::REG_CTRL, 32'h3);
		wr(seq_pkg::REG_INDEX, 32'h2);
		repeat (150) @(posedge ref_clk_in);
		n0 = n_load;
		// resume at held index, then wrap
		wr(seq_pkg::REG_CTRL, 32'h1);
		repeat (250) @(negedge ref_clk_in);
		chk("auto loads", 32'(n_load - n0), 32'h3);
		chk("auto wrap", 32'(index_out), 32'h0);
		wr(seq_pkg::REG_CTRL, 32'h0);
		wr(seq_pkg::REG_LEVEL_SPAN, 32'hc9);
		wr(seq_pkg::REG_CMD, 32'h108);
		rd(seq_pkg::REG_CMD);
		chk("span flag", 32'(rv[2]), 32'h1);
		chk("selected", 32'(rv[7:4]), 32'h1);
		rd(seq_pkg::REG_LENGTH);
		chk("other list", rv, 32'(seq_pkg::LIST_PAIRS_MAX - 3) << 16);
		wr(seq_pkg::REG_CMD, 32'h010);
		rd(seq_pkg::REG_LENGTH);
		chk("deleted", rv, 32'(seq_pkg::LIST_PAIRS_MAX) << 16);
	endtask
	task automatic t_seq();
		wr(seq_pkg::REG_CTRL, 32'h20);
		wr(seq_pkg::REG_LENGTH, 32'h2);
		wr(seq_pkg::REG_LENGTH, 32'h101);
		rd(seq_pkg::REG_LENGTH);
		chk("seq length", rv, (32'(seq_pkg::SEQ_ENTRIES_MAX - 2) << 16) | 32'h2);
		wr(seq_pkg::REG_SEQ_PTR, 32'h1);
		wr(seq_pkg::REG_SEQ_DATA, 32'h00090032);
		wr(seq_pkg::REG_SEQ_PTR, 32'h2);
		wr(seq_pkg::REG_SEQ_DATA, 32'h00020000);
		wr(seq_pkg::REG_SEQ_DATA, 32'h00330064);
		rd(seq_pkg::REG_SEQ_DATA);
		chk("clamped entry", rv, 32'h00020032);
		wr(seq_pkg::REG_SEQ_PTR, 32'h1);
		rd(seq_pkg::REG_SEQ_DATA);
		chk("first entry", rv, 32'h00090032);
		// stimulus only recalls locations, no level or modulation toggling
		wr(seq_pkg::REG_CTRL, 32'h23);
		wr(seq_pkg::REG_INDEX, 32'h2);
		@(negedge ref_clk_in);
		chk("recall second", 32'(recall_loc_out), 32'h2);
		chk("seq index", 32'(index_out), 32'h1);
		wr(seq_pkg::REG_INDEX, 32'h1);
		@(negedge ref_clk_in);
		chk("recall first", 32'(recall_loc_out), 32'h9);
	endtask
	// ---------------------------------------------
	// main
	// ---------------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
		{n_mismatch, checked, n_load} = '0;
		sys_rst_in = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		@(negedge ref_clk_in);
		t_reset();
		t_precompute_list_command();
		t_single();
		t_step();
		t_external_step_run();
		t_external_single_run();
		t_auto();
		t_seq();
		tally_and_finish();
	end
endmodule
